// ---- logic/spr_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - Control bit 0 enables engine; triggers ignored while disabled
// - Clearing enable while busy takes effect only after return to idle
// - Control bit 6 picks shared or per-sprite colour format
// - Shared format: 00 RGB565, 01 ARGB1555, 10 ARGB4444, 11 reserved
// - Control bit 1 selects double buffering; resets to 1
// - Writing 1 to reset bit 7 soft-resets engine; 0 does nothing
// - Soft reset acts only while engine enable is 1
// - Soft reset clears engine operation, keeps control registers
// - Sampling flag bit 7 is 1 while settings fetched from SDRAM
// - Status bit 7 reads 0 busy from trigger to completion; resets idle
// - Writing 1 to trigger bit 0 starts operation; 0 does nothing
// - Completion sets sticky done bit; software clears by writing 1
module spr_ctrl #(
  parameter int FETCH_LEN  = spr_pkg::FETCH_CYCLES,
  parameter int RENDER_LEN = spr_pkg::RENDER_CYCLES
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic [spr_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic                            irq,
  output logic                            engine_enabled,
  output logic                            engine_busy,
  output logic                            settings_sampling,
  output logic                            render_target,
  output logic      [1:0]                 pixel_format,
  output logic                            per_sprite_format
);
  logic [7:0] control;
  logic       enable_eff;
  logic       irq_en;
  logic       done_stat;
  logic       target;
  logic       rd_done;
  logic       seq_busy;
  logic       seq_sampling;
  logic       seq_done;
  logic       soft_rst;
  logic       start;
  logic       wr_ok;
  logic [15:0] idx;

  // Reserved control bits 7, 3 and 2 always read back as zero
  localparam logic [7:0] CTL_WR_MASK = 8'h73;

  // Byte address is four times the register index
  function automatic logic hit(input logic [spr_pkg::ADDR_W-1:0] a, input logic [15:0] i);
    return a == {i, 2'h0};
  endfunction

  // Writes complete in one cycle; reads get one wait cycle for a registered answer
  assign avs_waitrequest = avs_read && !rd_done;
  assign wr_ok           = avs_write && avs_byteenable[0];
  assign idx             = avs_address[spr_pkg::ADDR_W-1:2];

  assign start = wr_ok && hit(avs_address, spr_pkg::IDX_TRIGGER) &&
                 avs_writedata[spr_pkg::TRIG_BIT] && enable_eff && !seq_busy;
  assign soft_rst = wr_ok && hit(avs_address, spr_pkg::IDX_SRESET) &&
                    avs_writedata[spr_pkg::SRST_BIT] && control[spr_pkg::CTL_ENABLE];

  // soft reset touches only the sequencer's operation state and the render target
  spr_sequencer #(
    .FETCH_LEN  (FETCH_LEN),
    .RENDER_LEN (RENDER_LEN)
  ) u_seq (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .soft_rst (soft_rst),
    .start    (start),
    .busy     (seq_busy),
    .sampling (seq_sampling),
    .done     (seq_done)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control <= spr_pkg::CONTROL_RESET;
    end else if (wr_ok && hit(avs_address, spr_pkg::IDX_CONTROL)) begin
      control <= avs_writedata[7:0] & CTL_WR_MASK;
    end
  end

  // effective enable drops only once the engine is idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_eff <= 1'b0;
    end else if (control[spr_pkg::CTL_ENABLE]) begin
      enable_eff <= 1'b1;
    end else if (!seq_busy) begin
      enable_eff <= 1'b0;
    end
  end

  // buffer alternation, restarts at buffer 0 on any reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_rst) begin
      target <= 1'b0;
    end else if (seq_done) begin
      target <= control[spr_pkg::CTL_DOUBLE] ? ~target : 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
    end else if (wr_ok && hit(avs_address, spr_pkg::IDX_IRQ_EN)) begin
      irq_en <= avs_writedata[spr_pkg::DONE_BIT];
    end
  end

  // sticky done; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_stat <= 1'b0;
    end else if (seq_done) begin
      done_stat <= 1'b1;
    end else if (wr_ok && avs_writedata[spr_pkg::DONE_BIT] &&
                 (hit(avs_address, spr_pkg::IDX_IRQ_CLR) || hit(avs_address, spr_pkg::IDX_IRQ_STAT))) begin
      done_stat <= 1'b0;
    end
  end

  assign irq = irq_en && done_stat;

  // Registered read answer; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_done      <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rd_done <= avs_read && !rd_done;
      if (avs_read && !rd_done) begin
        avs_readdata <= '0;
        unique case (idx)
          spr_pkg::IDX_CONTROL:  avs_readdata[7:0] <= control;
          spr_pkg::IDX_SAMPLING: avs_readdata[spr_pkg::SAMPLING_BIT] <= seq_sampling;
          spr_pkg::IDX_STATE:    avs_readdata[spr_pkg::IDLE_BIT] <= !seq_busy;
          spr_pkg::IDX_IRQ_EN:   avs_readdata[spr_pkg::DONE_BIT] <= irq_en;
          spr_pkg::IDX_IRQ_STAT: avs_readdata[spr_pkg::DONE_BIT] <= done_stat;
          spr_pkg::IDX_ENG_INFO: avs_readdata[1:0] <= {target, enable_eff};
          default:               avs_readdata <= '0;
        endcase
      end
    end
  end

  assign engine_enabled    = enable_eff;
  assign engine_busy       = seq_busy;
  assign settings_sampling = seq_sampling;
  assign render_target     = target;
  // shared format forwarded only when individual formats are off
  assign per_sprite_format = control[spr_pkg::CTL_INDIV];
  assign pixel_format      = control[spr_pkg::CTL_INDIV] ? spr_pkg::FMT_RGB565
                           : control[spr_pkg::CTL_FMT_LO +: 2];

  sequence s_trig;
    start;
  endsequence

  // A reset request while disabled, with no completion to move the target
  sequence s_srst_refused;
    wr_ok && hit(avs_address, spr_pkg::IDX_SRESET) && avs_writedata[spr_pkg::SRST_BIT] &&
      !control[spr_pkg::CTL_ENABLE] && !seq_done;
  endsequence

  a_trig_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_trig |=> seq_busy) else $error("trigger did not start engine");
  a_disabled_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !enable_eff |-> !start) else $error("start while disabled");
  a_defer_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (seq_busy && enable_eff) |=> enable_eff) else $error("enable dropped while busy");
  a_reset_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_srst_refused |=> $stable(target)) else $error("soft reset while disabled");
  a_srst_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (soft_rst && !(wr_ok && hit(avs_address, spr_pkg::IDX_CONTROL))) |=> $stable(control))
    else $error("soft reset changed control");
  a_srst_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst |=> !seq_busy) else $error("soft reset left engine busy");
  a_sample_in_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_sampling |-> seq_busy) else $error("sampling while idle");
  a_done_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    seq_done |=> done_stat) else $error("done not latched");
  a_alt_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (seq_done && control[spr_pkg::CTL_DOUBLE] && !soft_rst) |=> target != $past(target))
    else $error("target did not alternate");
  a_single_buf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (seq_done && !control[spr_pkg::CTL_DOUBLE]) |=> !target) else $error("single mode not buffer 0");
  a_fmt_shared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !control[spr_pkg::CTL_INDIV] |-> pixel_format == control[spr_pkg::CTL_FMT_LO +: 2])
    else $error("format mismatch");
  a_busy_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_trig |=> seq_busy [*8]) else $error("busy too short");
  a_fmt_indiv: assert property (@(posedge ref_clk) disable iff (!rst_n)
    per_sprite_format == control[spr_pkg::CTL_INDIV]) else $error("individual select lost");
  a_trig_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_trig |=> seq_sampling) else $error("trigger did not start settings fetch");
  a_enable_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    control[spr_pkg::CTL_ENABLE] |=> enable_eff) else $error("enable not taken");
  a_done_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_ok && hit(avs_address, spr_pkg::IDX_IRQ_CLR) && avs_writedata[spr_pkg::DONE_BIT] && !seq_done)
    |=> !done_stat) else $error("done status not cleared");
  a_srst_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst |=> !target) else $error("soft reset kept buffer 1");
endmodule
`default_nettype wire

// ---- logic/spr_pkg.sv ----
`default_nettype none
package spr_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] IDX_CONTROL  = 16'h5000;
  localparam logic [15:0] IDX_SRESET   = 16'h5001;
  localparam logic [15:0] IDX_SAMPLING = 16'h5002;
  localparam logic [15:0] IDX_STATE    = 16'h5003;
  localparam logic [15:0] IDX_TRIGGER  = 16'h5004;
  localparam logic [15:0] IDX_IRQ_EN   = 16'h5006;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h5008;
  localparam logic [15:0] IDX_IRQ_CLR  = 16'h5009;
  localparam logic [15:0] IDX_ENG_INFO = 16'h500A;
  localparam int          ADDR_W       = 18;

  // Field positions
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_DOUBLE   = 1;
  localparam int CTL_FMT_LO   = 4;
  localparam int CTL_INDIV    = 6;
  localparam int SRST_BIT     = 7;
  localparam int SAMPLING_BIT = 7;
  localparam int IDLE_BIT     = 7;
  localparam int TRIG_BIT     = 0;
  localparam int DONE_BIT     = 1;

  localparam logic [7:0] CONTROL_RESET = 8'h02;
  localparam logic [7:0] STATE_RESET   = 8'h80;

  // Pixel formats of the shared colour format field
  localparam logic [1:0] FMT_RGB565   = 2'h0;
  localparam logic [1:0] FMT_ARGB1555 = 2'h1;
  localparam logic [1:0] FMT_ARGB4444 = 2'h2;
  localparam logic [1:0] FMT_RESERVED = 2'h3;

  // Length of settings fetch and of the render phase after it, in cycles
  localparam int FETCH_CYCLES  = 16;
  localparam int RENDER_CYCLES = 64;

  typedef enum logic [1:0] {
    SPR_IDLE,
    SPR_FETCH,
    SPR_RENDER
  } spr_state_t;
endpackage
`default_nettype wire

// ---- logic/spr_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the rendering pipeline: settings fetch, then render
module spr_sequencer #(
  parameter int FETCH_LEN  = spr_pkg::FETCH_CYCLES,
  parameter int RENDER_LEN = spr_pkg::RENDER_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic soft_rst,
  input  wire logic start,
  output logic      busy,
  output logic      sampling,
  output logic      done
);
  localparam int CW = 16;
  spr_pkg::spr_state_t state;
  logic [CW-1:0]       cnt;

  assign busy     = (state != spr_pkg::SPR_IDLE);
  assign sampling = (state == spr_pkg::SPR_FETCH);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_rst) begin
      state <= spr_pkg::SPR_IDLE;
      cnt   <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        spr_pkg::SPR_IDLE: begin
          if (start) begin
            state <= spr_pkg::SPR_FETCH;
            cnt   <= CW'(FETCH_LEN - 1);
          end
        end
        spr_pkg::SPR_FETCH: begin
          if (cnt == '0) begin
            state <= spr_pkg::SPR_RENDER;
            cnt   <= CW'(RENDER_LEN - 1);
          end else begin
            cnt <= cnt - CW'(1);
          end
        end
        spr_pkg::SPR_RENDER: begin
          if (cnt == '0) begin
            state <= spr_pkg::SPR_IDLE;
            done  <= 1'b1;
          end else begin
            cnt <= cnt - CW'(1);
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_sprite_engine_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_sprite_engine_control;
  localparam int FL = 8;
  localparam int RL = 20;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] avs_address = 18'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq, engine_enabled, engine_busy, settings_sampling, render_target, per_sprite_format;
  wire  [1:0]  pixel_format;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          bsy_c = 0;
  int          smp_c = 0;
  logic [31:0] seed = 32'h51;
  logic [7:0]  v;
  logic        tgt;

  always #4 ref_clk = ~ref_clk;

  spr_ctrl #(.FETCH_LEN(FL), .RENDER_LEN(RL)) i_spr_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .engine_enabled(engine_enabled), .engine_busy(engine_busy), .settings_sampling(settings_sampling),
    .render_target(render_target), .pixel_format(pixel_format), .per_sprite_format(per_sprite_format));

  // Busy and fetch lengths are measured here, independent of bus traffic
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (engine_busy === 1'b1) bsy_c <= bsy_c + 1;
    if (settings_sampling === 1'b1) smp_c <= smp_c + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, then an idle edge so strobes are never re-driven in one step
  // Only the bench watchdog ends a wait for the answer
  task automatic req(input logic [15:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] q);
    avs_address <= {idx, 2'h0};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    req(idx, 1'b1, d, q);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    req(idx, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask

  task automatic op(input bit dbl, input bit dis, input bit ien);
    int b0;
    int s0;
    b0 = bsy_c;
    s0 = smp_c;
    wr(spr_pkg::IDX_TRIGGER, 8'h01);
    // reads sampling flag and state while the flag is up; no settings area is written
    rdc(spr_pkg::IDX_SAMPLING, 32'h80);
    rdc(spr_pkg::IDX_STATE, 32'h00);
    // A second trigger while busy must not restart or extend the run
    wr(spr_pkg::IDX_TRIGGER, 8'h01);
    // Besides the second trigger, the only write while busy is the deferred disable
    if (dis) begin
      wr(spr_pkg::IDX_CONTROL, 8'h02);
      chk(engine_enabled, 1'b1);
    end
    while (engine_busy !== 1'b0) begin
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    tgt = dbl ? ~tgt : 1'b0;
    chk(bsy_c - b0, FL + RL);
    chk(smp_c - s0, FL);
    chk(render_target, tgt);
    chk(engine_enabled, !dis);
    rdc(spr_pkg::IDX_STATE, 32'h80);
    rdc(spr_pkg::IDX_IRQ_STAT, 32'h02);
    chk(irq, ien);
    wr(spr_pkg::IDX_IRQ_CLR, 8'h02);
    rdc(spr_pkg::IDX_IRQ_STAT, 32'h00);
    chk(irq, 1'b0);
  endtask

  initial begin
    tgt = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(spr_pkg::IDX_CONTROL, 32'h02);
    rdc(spr_pkg::IDX_STATE, 32'h80);
    rdc(spr_pkg::IDX_SAMPLING, 32'h00);
    rdc(16'h5010, 32'h00);
    wr(spr_pkg::IDX_TRIGGER, 8'h01);
    repeat (4) @(posedge ref_clk);
    chk(engine_busy, 1'b0);
    // First four pass every shared format, the rest are random
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      v = (i < 4) ? {2'h0, i[1:0], 4'h0} : seed[7:0];
      wr(spr_pkg::IDX_CONTROL, v);
      rdc(spr_pkg::IDX_CONTROL, {24'h0, v & 8'h73});
      chk(pixel_format, v[6] ? 2'b00 : v[5:4]);
      chk(per_sprite_format, v[6]);
      chk(engine_enabled, v[0]);
    end
    avs_byteenable <= 4'hE;
    wr(spr_pkg::IDX_CONTROL, 8'h00);
    avs_byteenable <= 4'hF;
    rdc(spr_pkg::IDX_CONTROL, {24'h0, v & 8'h73});
    wr(spr_pkg::IDX_CONTROL, 8'h03);
    wr(spr_pkg::IDX_TRIGGER, 8'h00);
    @(posedge ref_clk);
    chk(engine_busy, 1'b0);
    chk(render_target, 1'b0);
    // buffer and settings addresses lie outside this block and are never written
    for (int k = 0; k < 3; k++) begin
      // enable set and settings changed only while idle, before the trigger
      wr(spr_pkg::IDX_CONTROL, (k == 2) ? 8'h01 : 8'h03);
      wr(spr_pkg::IDX_IRQ_EN, (k == 2) ? 8'h00 : 8'h02);
      rdc(spr_pkg::IDX_IRQ_EN, (k == 2) ? 32'h00 : 32'h02);
      op(k != 2, k == 1, k != 2);
    end
    wr(spr_pkg::IDX_CONTROL, 8'h03);
    op(1'b1, 1'b0, 1'b0);
    wr(spr_pkg::IDX_CONTROL, 8'h02);
    rdc(spr_pkg::IDX_STATE, 32'h80);
    wr(spr_pkg::IDX_SRESET, 8'h80);
    chk(render_target, 1'b1);
    wr(spr_pkg::IDX_CONTROL, 8'h03);
    wr(spr_pkg::IDX_SRESET, 8'h7F);
    chk(render_target, 1'b1);
    wr(spr_pkg::IDX_SRESET, 8'h80);
    chk(render_target, 1'b0);
    rdc(spr_pkg::IDX_CONTROL, 32'h03);
    rdc(spr_pkg::IDX_ENG_INFO, 32'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
